//--- rtl/bis_regs.svh
/*
 * timing constants for the burner ignition sequencer.
 * assumes a 10 MHz system clock; included by its bare name.
 */
`ifndef BIS_REGS_SVH
`define BIS_REGS_SVH

// ------------------------------------------------------------
// clock and phase times
// ------------------------------------------------------------
`define BIS_CLK_HZ           10000000
`define BIS_SELFCHK_S        2
`define BIS_PREPURGE_S       15
`define BIS_WARMUP_S         20
`define BIS_TRIAL_S          6
`define BIS_IGN_OFF_S        2
`define BIS_PROVE_S          2
`define BIS_FAIL_S           4
`define BIS_POSTPURGE_S      30
`define BIS_AFTERGLOW_S      2

// ------------------------------------------------------------
// high limit setpoint window, degrees F
// ------------------------------------------------------------
`define BIS_LIMIT_MIN_F      8'h64
`define BIS_LIMIT_MAX_F      8'hC8
`define BIS_LIMIT_DIFF_F     8'h14

`endif

//--- rtl/bis_pkg.sv
/*
 * types for the burner ignition sequencer.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package bis_pkg;

   // ------------------------------------------------------------
   // sequence states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_STANDBY,
      ST_SELFCHK,
      ST_WAIT_AIR,
      ST_PREPURGE,
      ST_WARMUP,
      ST_TRIAL,
      ST_RUN,
      ST_HOLD,
      ST_POSTPURGE
   } bis_state_e;

   // ------------------------------------------------------------
   // load outputs and lamps
   // ------------------------------------------------------------
   typedef struct packed {
      logic circulator;
      logic inducer;
      logic igniter;
      logic gas_valve;
   } bis_loads_s;

   typedef struct packed {
      logic power;
      logic purge;
      logic igniter;
      logic valve;
      logic flame_dim;
      logic flame_full;
   } bis_lamps_s;

endpackage

//--- rtl/bis_sync.sv
/*
 * two-flop synchroniser for a bundle of pin levels.
 * assumes the pins are asynchronous to sys_clk_in.
 */
`timescale 1ns/1ps
module bis_sync #(
   parameter int WIDTH = 5
) (
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             reset_in,
   // pin side
   input  wire logic [WIDTH-1:0] pins_in,
   // synchronised side
   output      logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= pins_in;
         sync_out <= stage1;
      end
   end

endmodule

//--- rtl/bis_sequencer.sv
/*
 * burner ignition sequencer: thermostat-driven purge, ignite, prove, run, post-purge.
 * assumes 10 MHz sys_clk_in, asynchronous pins, and an external thermostat,
 * air proving switch, flame sensor and limit controls.
 */
// Notes on behaviour
// RQ1 - idle with power: power lamp lit, all loads off, wait for heat request.
// RQ2 - heat request energizes the circulator at once.
// RQ3 - about two seconds of self-check, then the draft inducer starts.
// RQ4 - air switch closure lights purge lamp and starts fifteen second pre-purge.
// RQ5 - pre-purge end: purge lamp off, igniter and igniter lamp on, twenty seconds.
// RQ6 - warm-up end: gas valve and valve lamp on, six second trial.
// RQ7 - two seconds after valve opens, igniter and its lamp go off.
// RQ8 - flame lamp dim at proving start; last two seconds prove flame, lamp full.
// RQ9 - heat request end: valve and circulator off, thirty second post-purge, purge lamp.
// RQ10 - flame lamp follows flame about two seconds after valve closes.
// RQ11 - post-purge end: inducer off, back to standby.
// RQ12 - no flame in trial: valve and lamp off four seconds after opening.
// RQ13 - high limit exceeded while firing: burner off, circulator keeps running.
// RQ14 - limit clears: relight only after repeating pre-purge and warm-up.
// RQ15 - high limit setpoint held within 100 to 200 F, differential 20 F.
// RQ16 - opened safety control shuts burner off; restored control relights it.
// RQ17 - air switch never closes: inducer stays on, no further advance.
// RQ18 - heat request dropped during purge, warm-up or trial: valve, igniter off, post-purge.
`timescale 1ns/1ps
`include "bis_regs.svh"
module bis_sequencer #(
   parameter int SELFCHK_CYC   = `BIS_SELFCHK_S * `BIS_CLK_HZ,
   parameter int PREPURGE_CYC  = `BIS_PREPURGE_S * `BIS_CLK_HZ,
   parameter int WARMUP_CYC    = `BIS_WARMUP_S * `BIS_CLK_HZ,
   parameter int TRIAL_CYC     = `BIS_TRIAL_S * `BIS_CLK_HZ,
   parameter int IGN_OFF_CYC   = `BIS_IGN_OFF_S * `BIS_CLK_HZ,
   parameter int PROVE_CYC     = `BIS_PROVE_S * `BIS_CLK_HZ,
   parameter int FAIL_CYC      = `BIS_FAIL_S * `BIS_CLK_HZ,
   parameter int POSTPURGE_CYC = `BIS_POSTPURGE_S * `BIS_CLK_HZ,
   parameter int AFTERGLOW_CYC = `BIS_AFTERGLOW_S * `BIS_CLK_HZ
) (
   // clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              reset_in,
   // external contacts (asynchronous)
   input  wire logic              supply_ok_in,
   input  wire logic              heat_req_in,
   input  wire logic              air_proven_in,
   input  wire logic              flame_in,
   input  wire logic              safety_ok_in,
   // boiler water temperature and limit setting, degrees F
   input  wire logic [7:0]        water_temp_in,
   input  wire logic [7:0]        limit_set_in,
   // loads
   output bis_pkg::bis_loads_s    loads_out,
   // diagnostic lamps
   output bis_pkg::bis_lamps_s    lamps_out,
   // status
   output bis_pkg::bis_state_e    state_out,
   output logic                   ignition_fail_out,
   output logic [7:0]             limit_eff_out
);

   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------
   logic [4:0] pin_sync;
   logic       power_s;
   logic       heat_s;
   logic       air_s;
   logic       flame_s;
   logic       safety_s;

   bis_sync #(.WIDTH(5)) u_sync (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pins_in    ({supply_ok_in, heat_req_in, air_proven_in, flame_in, safety_ok_in}),
      .sync_out   (pin_sync)
   );

   assign power_s  = pin_sync[4];
   assign heat_s   = pin_sync[3];
   assign air_s    = pin_sync[2];
   assign flame_s  = pin_sync[1];
   assign safety_s = pin_sync[0];

   // temperature words are assumed quasi-static; sampled twice anyway
   logic [7:0] temp_q1;
   logic [7:0] temp_q;
   logic [7:0] set_q1;
   logic [7:0] set_q;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         temp_q1 <= 8'h00;
         temp_q  <= 8'h00;
         set_q1  <= `BIS_LIMIT_MAX_F;
         set_q   <= `BIS_LIMIT_MAX_F;
      end else begin
         temp_q1 <= water_temp_in;
         temp_q  <= temp_q1;
         set_q1  <= limit_set_in;
         set_q   <= set_q1;
      end
   end

   // ------------------------------------------------------------
   // high limit with clamped setpoint and differential
   // ------------------------------------------------------------
   function automatic logic [7:0] clamp_limit(input logic [7:0] v);
      if (v < `BIS_LIMIT_MIN_F)
         clamp_limit = `BIS_LIMIT_MIN_F;
      else if (v > `BIS_LIMIT_MAX_F)
         clamp_limit = `BIS_LIMIT_MAX_F;
      else
         clamp_limit = v;
   endfunction

   logic [7:0] limit_eff;
   logic [7:0] limit_low;
   logic       limit_trip;
   wire        over_limit  = temp_q > limit_eff;
   wire        under_limit = temp_q <= limit_low;

   // RQ15 - setpoint window clamp
   assign limit_eff = clamp_limit(set_q);
   assign limit_low = limit_eff - `BIS_LIMIT_DIFF_F;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in)
         limit_trip <= 1'b0;
      else if (over_limit)
         limit_trip <= 1'b1;
      else if (under_limit)
         limit_trip <= 1'b0;
   end

   // RQ13 - limit or safety blocks firing
   // RQ16 - safety control shutoff
   wire burner_block = limit_trip | ~safety_s;

   // ------------------------------------------------------------
   // sequence state machine
   // ------------------------------------------------------------
   bis_pkg::bis_state_e state;
   bis_pkg::bis_state_e next_state;
   logic [31:0]         timer;
   logic [31:0]         next_timer;
   logic                flame_proved;
   logic                next_flame_proved;
   logic                ign_fail;
   logic                next_ign_fail;

   function automatic logic expired(input logic [31:0] t, input int lim);
      expired = (t >= 32'(lim - 1));
   endfunction

   always_comb begin
      next_state        = state;
      next_timer        = timer + 32'h1;
      next_flame_proved = flame_proved;
      next_ign_fail     = ign_fail;
      case (state)
         bis_pkg::ST_STANDBY: begin
            next_timer        = 32'h0;
            next_flame_proved = 1'b0;
            // RQ2 - heat request starts cycle
            if (power_s && heat_s) begin
               next_state    = bis_pkg::ST_SELFCHK;
               next_ign_fail = 1'b0;
            end
         end
         bis_pkg::ST_SELFCHK: begin
            // RQ3 - self-check then inducer
            if (!heat_s) begin
               next_state = bis_pkg::ST_STANDBY;
            end else if (expired(timer, SELFCHK_CYC)) begin
               next_state = bis_pkg::ST_WAIT_AIR;
               next_timer = 32'h0;
            end
         end
         bis_pkg::ST_WAIT_AIR: begin
            next_timer = 32'h0;
            // RQ17 - hold until air proven
            // RQ18 - request drop goes to post-purge
            if (!heat_s)
               next_state = bis_pkg::ST_POSTPURGE;
            else if (air_s && !burner_block)
               next_state = bis_pkg::ST_PREPURGE;
         end
         bis_pkg::ST_PREPURGE: begin
            // RQ4 - fifteen second pre-purge
            if (!heat_s) begin
               next_state = bis_pkg::ST_POSTPURGE;
               next_timer = 32'h0;
            end else if (!air_s || burner_block) begin
               next_state = bis_pkg::ST_WAIT_AIR;
               next_timer = 32'h0;
            end else if (expired(timer, PREPURGE_CYC)) begin
               next_state = bis_pkg::ST_WARMUP;
               next_timer = 32'h0;
            end
         end
         bis_pkg::ST_WARMUP: begin
            // RQ5 - twenty second warm-up
            if (!heat_s) begin
               next_state = bis_pkg::ST_POSTPURGE;
               next_timer = 32'h0;
            end else if (!air_s || burner_block) begin
               next_state = bis_pkg::ST_HOLD;
               next_timer = 32'h0;
            end else if (expired(timer, WARMUP_CYC)) begin
               next_state = bis_pkg::ST_TRIAL;
               next_timer = 32'h0;
            end
         end
         bis_pkg::ST_TRIAL: begin
            // RQ8 - prove in final window
            if (flame_s && timer >= 32'(TRIAL_CYC - PROVE_CYC))
               next_flame_proved = 1'b1;
            if (!heat_s) begin
               next_state = bis_pkg::ST_POSTPURGE;
               next_timer = 32'h0;
            end else if (!air_s || burner_block) begin
               next_state = bis_pkg::ST_HOLD;
               next_timer = 32'h0;
            // RQ12 - no flame closes valve
            end else if (!flame_s && expired(timer, FAIL_CYC)) begin
               next_state    = bis_pkg::ST_STANDBY;
               next_ign_fail = 1'b1;
            end else if (expired(timer, TRIAL_CYC)) begin
               next_state = flame_s ? bis_pkg::ST_RUN : bis_pkg::ST_STANDBY;
               next_ign_fail = ~flame_s;
               next_timer = 32'h0;
            end
         end
         bis_pkg::ST_RUN: begin
            next_timer = 32'h0;
            // RQ9 - end of call, post-purge
            if (!heat_s)
               next_state = bis_pkg::ST_POSTPURGE;
            // RQ13 - limit trip shuts burner
            else if (!air_s || burner_block || !flame_s)
               next_state = bis_pkg::ST_HOLD;
         end
         bis_pkg::ST_HOLD: begin
            next_timer        = 32'h0;
            next_flame_proved = 1'b0;
            // RQ14 - relight via full purge
            if (!heat_s)
               next_state = bis_pkg::ST_POSTPURGE;
            else if (!burner_block)
               next_state = bis_pkg::ST_WAIT_AIR;
         end
         bis_pkg::ST_POSTPURGE: begin
            // RQ11 - post-purge end to standby
            if (expired(timer, POSTPURGE_CYC)) begin
               next_state = bis_pkg::ST_STANDBY;
               next_timer = 32'h0;
            end
         end
         default: begin
            next_state = bis_pkg::ST_STANDBY;
            next_timer = 32'h0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state        <= bis_pkg::ST_STANDBY;
         timer        <= 32'h0;
         flame_proved <= 1'b0;
         ign_fail     <= 1'b0;
      end else begin
         state        <= next_state;
         timer        <= next_timer;
         flame_proved <= next_flame_proved;
         ign_fail     <= next_ign_fail;
      end
   end

   // ------------------------------------------------------------
   // flame lamp afterglow
   // ------------------------------------------------------------
   logic [31:0] glow;

   // RQ10 - flame lamp follows flame
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in)
         glow <= 32'h0;
      else if (state == bis_pkg::ST_RUN && next_state == bis_pkg::ST_POSTPURGE)
         glow <= 32'(AFTERGLOW_CYC);
      else if (glow != 32'h0)
         glow <= glow - 32'h1;
   end

   // ------------------------------------------------------------
   // output decode
   // ------------------------------------------------------------
   bis_pkg::bis_loads_s next_loads;
   bis_pkg::bis_lamps_s next_lamps;
   wire s_fire  = next_state == bis_pkg::ST_TRIAL || next_state == bis_pkg::ST_RUN;
   wire s_trial = next_state == bis_pkg::ST_TRIAL;
   wire ign_win = s_trial && next_timer < 32'(IGN_OFF_CYC);
   wire heating = next_state != bis_pkg::ST_STANDBY && next_state != bis_pkg::ST_POSTPURGE;

   // RQ1 - standby lamp, loads off
   assign next_lamps.power      = power_s;
   // RQ4 - purge lamp with pre-purge
   // RQ9 - purge lamp in post-purge
   assign next_lamps.purge      = next_state == bis_pkg::ST_PREPURGE || next_state == bis_pkg::ST_POSTPURGE;
   // RQ5 - igniter lamp with igniter
   // RQ7 - igniter off after two seconds
   assign next_lamps.igniter    = next_state == bis_pkg::ST_WARMUP || ign_win;
   // RQ6 - valve lamp with valve
   assign next_lamps.valve      = s_fire;
   // RQ8 - dim then full flame lamp
   assign next_lamps.flame_dim  = s_trial && !next_flame_proved;
   assign next_lamps.flame_full = (s_fire && next_flame_proved) || (glow != 32'h0 && flame_s)
                                  || (next_state == bis_pkg::ST_RUN) || (state == bis_pkg::ST_RUN && flame_s);

   // RQ2 - circulator during call
   // RQ13 - circulator kept on limit
   assign next_loads.circulator = heating && next_state != bis_pkg::ST_SELFCHK ? 1'b1 : heating;
   // RQ3 - inducer after self-check
   assign next_loads.inducer    = heating ? next_state != bis_pkg::ST_SELFCHK : next_state == bis_pkg::ST_POSTPURGE;
   assign next_loads.igniter    = next_lamps.igniter;
   // RQ6 - gas valve through trial and run
   assign next_loads.gas_valve  = s_fire;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         loads_out         <= '0;
         lamps_out         <= '0;
         state_out         <= bis_pkg::ST_STANDBY;
         ignition_fail_out <= 1'b0;
         limit_eff_out     <= `BIS_LIMIT_MAX_F;
      end else begin
         loads_out         <= next_loads;
         lamps_out         <= next_lamps;
         state_out         <= next_state;
         ignition_fail_out <= next_ign_fail;
         limit_eff_out     <= limit_eff;
      end
   end

endmodule

//--- verification/bis_checker.sv
/* checker for bis_sequencer ports.
   bound to every bis_sequencer instance; sees ports only. */
`timescale 1ns/1ps
module bis_checker #(
   parameter int IGN_OFF_CYC = 4
) (
   input wire logic           sys_clk_in,
   input wire logic           reset_in,
   input wire logic           supply_ok_in,
   input wire logic           heat_req_in,
   input wire logic           air_proven_in,
   input wire logic           flame_in,
   input wire logic           safety_ok_in,
   input wire logic [7:0]     water_temp_in,
   input wire logic [7:0]     limit_set_in,
   input bis_pkg::bis_loads_s loads_out,
   input bis_pkg::bis_lamps_s lamps_out,
   input bis_pkg::bis_state_e state_out,
   input wire logic           ignition_fail_out,
   input wire logic [7:0]     limit_eff_out
);
   localparam int IGN_SLACK = IGN_OFF_CYC;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   a_standby_loads_off: assert property (state_out == bis_pkg::ST_STANDBY |->
      !loads_out.igniter && !loads_out.gas_valve) else $error("load on in standby");
   a_selfchk_order: assert property (state_out == bis_pkg::ST_SELFCHK |->
      loads_out.circulator && !loads_out.inducer) else $error("self-check loads wrong");
   a_wait_air_hold: assert property (state_out == bis_pkg::ST_WAIT_AIR |->
      loads_out.inducer && !loads_out.igniter && !loads_out.gas_valve) else $error("advanced without air");
   a_igniter_lamps: assert property (loads_out.igniter |->
      !lamps_out.purge && lamps_out.igniter) else $error("igniter lamps wrong");
   a_valve_open: assert property ($rose(loads_out.gas_valve) |->
      loads_out.igniter && lamps_out.valve && lamps_out.flame_dim) else $error("valve open lamps wrong");
   a_igniter_cut: assert property ($rose(loads_out.gas_valve) |->
      loads_out.igniter[*3] ##[0:IGN_SLACK] !loads_out.igniter) else $error("igniter not cut");
   a_fail_closes: assert property ($rose(ignition_fail_out) |->
      !loads_out.gas_valve && !lamps_out.valve) else $error("valve open after fail");
   a_hold_burner_off: assert property (state_out == bis_pkg::ST_HOLD |->
      loads_out.circulator && !loads_out.igniter && !loads_out.gas_valve) else $error("burner on in hold");
   a_postpurge_out: assert property (state_out == bis_pkg::ST_POSTPURGE |->
      loads_out.inducer && lamps_out.purge && !loads_out.gas_valve && !loads_out.circulator
      && !lamps_out.valve) else $error("post-purge outputs wrong");
   a_limit_window: assert property (limit_eff_out >= 8'h64 && limit_eff_out <= 8'hC8)
      else $error("limit out of window");
endmodule

bind bis_sequencer bis_checker #(.IGN_OFF_CYC(IGN_OFF_CYC)) chk_u (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .supply_ok_in(supply_ok_in),
   .heat_req_in(heat_req_in), .air_proven_in(air_proven_in), .flame_in(flame_in),
   .safety_ok_in(safety_ok_in), .water_temp_in(water_temp_in), .limit_set_in(limit_set_in),
   .loads_out(loads_out), .lamps_out(lamps_out), .state_out(state_out),
   .ignition_fail_out(ignition_fail_out), .limit_eff_out(limit_eff_out));

//--- verification/bis_far_model.sv
/* air proving switch and flame sensor model.
   assumes loads from the sequencer; drives on the falling edge. */
`timescale 1ns/1ps
module bis_far_model (
   // clock
   input  wire logic          sys_clk_in,
   // loads and scenario switches
   input  bis_pkg::bis_loads_s loads_in,
   input  wire logic          air_en_in,
   input  wire logic          flame_en_in,
   // contacts
   output logic               air_out,
   output logic               flame_out
);
   int air_cnt  = 0;
   int burn_cnt = 0;
   initial begin
      air_out = 1'b0;
      flame_out = 1'b0;
   end
   always @(negedge sys_clk_in) begin
      air_cnt <= (loads_in.inducer && air_en_in) ? air_cnt + 1 : 0;
      air_out <= (air_cnt >= 5);
   end
   // residual gas burns a few cycles
   always @(negedge sys_clk_in) begin
      if (loads_in.gas_valve && flame_en_in) begin
         burn_cnt <= 4;
      end else if (burn_cnt > 0) begin
         burn_cnt <= burn_cnt - 1;
      end
      flame_out <= (burn_cnt > 0);
   end
endmodule

//--- verification/testbench.sv
/* self-checking bench for bis_sequencer.
   assumes short phase parameters and the far-side model. */
`timescale 1ns/1ps
module testbench;
   localparam int SC = 20, PP = 30, WU = 40, TR = 12, IG = 4, PV = 4, FL = 8, PG = 60;
   logic                sys_clk_in, reset_in, supply_ok_in, heat_req_in, safety_ok_in;
   logic                air_en, flame_en, air_proven_in, flame_in, ignition_fail_out;
   logic [7:0]          water_temp_in, limit_set_in, limit_eff_out;
   bis_pkg::bis_loads_s loads_out;
   bis_pkg::bis_lamps_s lamps_out;
   bis_pkg::bis_state_e state_out;
   int                  n_fail = 0, compares = 0, cyc = 0, n;
   wire [7:0]           obs = {loads_out, lamps_out.purge, lamps_out.flame_full,
                               ignition_fail_out, lamps_out.igniter};

   bis_sequencer #(.SELFCHK_CYC(SC), .PREPURGE_CYC(PP), .WARMUP_CYC(WU), .TRIAL_CYC(TR),
      .IGN_OFF_CYC(IG), .PROVE_CYC(PV), .FAIL_CYC(FL), .POSTPURGE_CYC(PG), .AFTERGLOW_CYC(4)) dut_u (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .supply_ok_in(supply_ok_in),
      .heat_req_in(heat_req_in), .air_proven_in(air_proven_in), .flame_in(flame_in),
      .safety_ok_in(safety_ok_in), .water_temp_in(water_temp_in), .limit_set_in(limit_set_in),
      .loads_out(loads_out), .lamps_out(lamps_out), .state_out(state_out),
      .ignition_fail_out(ignition_fail_out), .limit_eff_out(limit_eff_out));
   bis_far_model fm_u (.sys_clk_in(sys_clk_in), .loads_in(loads_out), .air_en_in(air_en),
      .flame_en_in(flame_en), .air_out(air_proven_in), .flame_out(flame_in));

   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task report_and_stop;
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   task chk_rng(input string nm, input int lo, input int hi, input int g);
      compares++;
      if (g < lo || g > hi) begin
         n_fail++;
         $display("FAIL %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask
   task wt(input int b, input logic v, output int c);
      c = 0;
      do begin
         @(negedge sys_clk_in);
         c++;
      end while (obs[b] !== v && c < 400);
      if (c >= 400) chk("wait", 8'(b), 8'hFF);
   endtask
   task tick(input int k);
      repeat (k) @(negedge sys_clk_in);
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task s_nopower;
      supply_ok_in = 1'b0;
      heat_req_in = 1'b1;
      tick(6);
      chk("nopow_lamp", 8'(lamps_out.power), 8'h00);
      chk("nopow_st", 8'(state_out), 8'(bis_pkg::ST_STANDBY));
      chk("nopow_loads", 8'(loads_out), 8'h00);
      heat_req_in = 1'b0;
      supply_ok_in = 1'b1;
      tick(4);
   endtask
   task s_clamp;
      logic [7:0] ci[5];
      logic [7:0] ce[5];
      ci = '{8'h20, 8'hFF, 8'h90, 8'h64, 8'hC8};
      ce = '{8'h64, 8'hC8, 8'h90, 8'h64, 8'hC8};
      for (int i = 0; i < 5; i++) begin
         limit_set_in = ci[i];
         tick(5);
         chk("limit_eff", limit_eff_out, ce[i]);
      end
      limit_set_in = 8'hB4;
   endtask
   task s_normal;
      heat_req_in = 1'b1;
      tick(3);
      chk("circ", 8'(loads_out.circulator), 8'h01);
      chk("ind", 8'(loads_out.inducer), 8'h00);
      wt(6, 1'b1, n);
      chk_rng("selfchk", SC - 2, SC + 2, n);
      wt(3, 1'b1, n);
      wt(5, 1'b1, n);
      chk_rng("prepurge", PP - 2, PP + 2, n);
      chk("purge", 8'(lamps_out.purge), 8'h00);
      wt(4, 1'b1, n);
      chk_rng("warmup", WU - 2, WU + 2, n);
      chk("dim", 8'(lamps_out.flame_dim), 8'h01);
      wt(5, 1'b0, n);
      chk_rng("ign_cut", IG - 2, IG + 2, n);
      chk("ign_lamp", 8'(lamps_out.igniter), 8'h00);
      wt(2, 1'b1, n);
      chk_rng("prove", TR - PV - IG - 1, TR - IG + 2, n);
      tick(TR);
      chk("run", 8'(state_out), 8'(bis_pkg::ST_RUN));
      heat_req_in = 1'b0;
      tick(3);
      chk("post", 8'(obs[7:3]), 8'h09);
      chk("vlamp", 8'(lamps_out.valve), 8'h00);
      chk("glow", 8'(lamps_out.flame_full), 8'h01);
      wt(6, 1'b0, n);
      chk_rng("postpurge", PG - 2, PG + 2, n);
      chk("standby", 8'(state_out), 8'(bis_pkg::ST_STANDBY));
   endtask
   task s_noflame;
      flame_en = 1'b0;
      heat_req_in = 1'b1;
      wt(4, 1'b1, n);
      wt(4, 1'b0, n);
      chk_rng("fail_t", FL - 2, FL + 2, n);
      chk("fail", 8'(ignition_fail_out), 8'h01);
      tick(1);
      chk("fail_rst", 8'(ignition_fail_out), 8'h00);
      heat_req_in = 1'b0;
      flame_en = 1'b1;
      tick(80);
   endtask
   task s_limit_safety;
      heat_req_in = 1'b1;
      tick(4);
      chk("fail_clr", 8'(ignition_fail_out), 8'h00);
      wt(4, 1'b1, n);
      tick(TR + 4);
      water_temp_in = 8'hC0;
      tick(24);
      chk("hold", 8'(obs[7:4]), 8'h0C);
      water_temp_in = 8'h50;
      wt(3, 1'b1, n);
      wt(5, 1'b1, n);
      chk_rng("re_purge", PP - 2, PP + 2, n);
      wt(4, 1'b1, n);
      chk_rng("re_warm", WU - 2, WU + 2, n);
      tick(TR + 4);
      safety_ok_in = 1'b0;
      tick(4);
      chk("safe_off", 8'(loads_out.gas_valve), 8'h00);
      safety_ok_in = 1'b1;
      wt(4, 1'b1, n);
      chk_rng("relight", PP + WU - 2, PP + WU + 30, n);
      heat_req_in = 1'b0;
      tick(3);
      chk("abort", 8'(obs[5:4]), 8'h00);
      chk("abort_st", 8'(state_out), 8'(bis_pkg::ST_POSTPURGE));
      wt(6, 1'b0, n);
   endtask
   task s_noair;
      air_en = 1'b0;
      heat_req_in = 1'b1;
      wt(6, 1'b1, n);
      tick(100);
      chk("noair", 8'(obs[6:4]), 8'h04);
      chk("noair_st", 8'(state_out), 8'(bis_pkg::ST_WAIT_AIR));
      heat_req_in = 1'b0;
      air_en = 1'b1;
      tick(4);
      chk("drop_st", 8'(state_out), 8'(bis_pkg::ST_POSTPURGE));
      wt(6, 1'b0, n);
   endtask

   initial begin
      reset_in = 1'b1;
      supply_ok_in = 1'b1;
      heat_req_in = 1'b0;
      safety_ok_in = 1'b1;
      air_en = 1'b1;
      flame_en = 1'b1;
      water_temp_in = 8'h50;
      limit_set_in = 8'hB4;
      tick(8);
      chk("rst_loads", 8'(loads_out), 8'h00);
      reset_in = 1'b0;
      tick(4);
      chk("power", 8'(lamps_out.power), 8'h01);
      s_nopower();
      s_clamp();
      s_normal();
      s_noflame();
      s_limit_safety();
      s_noair();
      report_and_stop();
   end
endmodule
